// ===== data_move_exec.v
// executes the four data-move instructions of the core, one quarter phase per clock
// assumes the fetch stage holds the program word steady through phase one of each
// instruction cycle and that data memory reads combinationally while mem_rd_en is high
`timescale 1ns/1ps
`include "data_move_defines.vh"

module data_move_exec #(
    parameter ADDR_W = 12,
    parameter DATA_W = 8
) (
    input wire core_clk,
    input wire srst,
    input wire [15:0] instr_word,
    input wire instr_valid,
    input wire skip_in,
    input wire [DATA_W-1:0] mem_rdata,
    output reg [ADDR_W-1:0] mem_addr,
    output reg mem_rd_en,
    output reg mem_wr_en,
    output reg [DATA_W-1:0] mem_wdata,
    output reg [DATA_W-1:0] working,
    output reg [3:0] bank_select_register,
    output reg [1:0] phase,
    output reg copy_pending,
    output reg illegal_word
);

    // operations held for the current instruction cycle
    localparam OP_NOP = 3'h0;
    localparam OP_COPY_READ = 3'h1;
    localparam OP_COPY_WRITE = 3'h2;
    localparam OP_LOAD_BANK = 3'h3;
    localparam OP_LOAD_WORKING = 3'h4;
    localparam OP_STORE_WORKING = 3'h5;

    // sequencer states
    // the second state only exists for the copy's destination word
    localparam ST_FIRST = 1'b0;
    localparam ST_SECOND = 1'b1;

    // held for one instruction cycle; state, skip_second and copy_byte carry a copy across two
    reg [2:0] op;
    reg state;
    reg skip_second;
    reg [ADDR_W-1:0] dst_addr;
    reg [DATA_W-1:0] copy_byte;
    reg [DATA_W-1:0] literal;
    reg [ADDR_W-1:0] file_addr;

    // decode results, latched only at the edge that closes phase one
    reg [2:0] next_op;
    reg next_state;
    reg next_skip_second;
    reg next_illegal;

    // banked or access-bank address of an 8-bit file operand
    function [11:0] file_address;
        input [7:0] f;
        input a;
        input [3:0] bank;
        begin
            // a bank loaded in phase four is seen from the next decode on
            if (a) begin
                file_address = {bank, f};
            end else if (f[`ACCESS_SPLIT_BIT]) begin
                file_address = {`PAGE_HIGH, f};
            end else begin
                file_address = {`PAGE_LOW, f};
            end
        end
    endfunction

    // decode of the word seen in phase one
    always @* begin
        next_op = OP_NOP;
        next_state = ST_FIRST;
        next_skip_second = 1'b0;
        next_illegal = 1'b0;
        case (state)
            ST_FIRST: begin
                if (instr_valid && instr_word[15:12] == `NIB_COPY_SRC) begin
                    // a skipped copy still eats its second word as a no-op
                    next_state = ST_SECOND;
                    next_skip_second = skip_in;
                    next_op = skip_in ? OP_NOP : OP_COPY_READ;
                end else if (instr_valid && !skip_in) begin
                    if (instr_word[15:8] == `BYTE_LOAD_BANK) begin
                        next_op = OP_LOAD_BANK;
                    end else if (instr_word[15:8] == `BYTE_LOAD_WORKING) begin
                        next_op = OP_LOAD_WORKING;
                    end else if (instr_word[15:9] == `SEVEN_STORE_WORKING) begin
                        next_op = OP_STORE_WORKING;
                    end else begin
                        next_op = OP_NOP; // other instructions belong elsewhere
                    end
                end else begin
                    next_op = OP_NOP;
                end
            end
            ST_SECOND: begin
                // a skipped copy swallows its second word without raising illegal_word
                if (skip_second) begin
                    next_op = OP_NOP;
                end else if (instr_valid && instr_word[15:12] == `NIB_COPY_DST) begin
                    next_op = OP_COPY_WRITE;
                end else begin
                    // missing destination word: drop the copy rather than write junk
                    next_op = OP_NOP;
                    next_illegal = 1'b1;
                end
            end
            default: begin
                next_op = OP_NOP;
            end
        endcase
    end

    // free-running quarter phase counter
    // nothing stalls it, so the fetch side aligns its words to phase one by watching it
    always @(posedge core_clk) begin
        if (srst) begin
            phase <= `PH_Q1;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // latch decode and operands at the close of phase one
    always @(posedge core_clk) begin
        if (srst) begin
            op <= OP_NOP;
            state <= ST_FIRST;
            skip_second <= 1'b0;
            dst_addr <= {ADDR_W{1'b0}};
            literal <= {DATA_W{1'b0}};
            file_addr <= {ADDR_W{1'b0}};
            copy_pending <= 1'b0;
            illegal_word <= 1'b0;
        end else if (phase == `PH_Q1) begin
            op <= next_op;
            state <= next_state;
            skip_second <= next_skip_second;
            copy_pending <= (next_state == ST_SECOND);
            illegal_word <= next_illegal;
            // taken on every decode; only the two load operations consume it
            literal <= instr_word[7:0];
            // full 12-bit operands bypass bank selection
            if (next_op == OP_COPY_WRITE) begin
                dst_addr <= instr_word[11:0];
            end
            file_addr <= file_address(instr_word[7:0], instr_word[8],
                                      bank_select_register);
        end else begin
            illegal_word <= 1'b0;
        end
    end

    // data memory strobes: read in phase two, write in phase four
    always @(posedge core_clk) begin
        if (srst) begin
            mem_addr <= {ADDR_W{1'b0}};
            mem_rd_en <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_wdata <= {DATA_W{1'b0}};
            copy_byte <= {DATA_W{1'b0}};
        end else begin
            mem_rd_en <= 1'b0;
            mem_wr_en <= 1'b0;
            case (phase)
                `PH_Q1: begin
                    if (next_op == OP_COPY_READ) begin
                        mem_addr <= instr_word[11:0];
                        mem_rd_en <= 1'b1;
                    end else if (next_op == OP_STORE_WORKING) begin
                        // the store reads its target like any file operand; the byte is unused
                        mem_addr <= file_address(instr_word[7:0], instr_word[8],
                                                 bank_select_register);
                        mem_rd_en <= 1'b1;
                    end
                    // second copy cycle issues no dummy read
                end
                `PH_Q2: begin
                    // memory answers combinationally, so the byte is caught as phase two closes
                    if (op == OP_COPY_READ) begin
                        copy_byte <= mem_rdata;
                    end
                end
                `PH_Q3: begin
                    // strobes raised here stand through phase four; memory writes as it closes
                    if (op == OP_COPY_WRITE) begin
                        mem_addr <= dst_addr;
                        mem_wdata <= copy_byte;
                        mem_wr_en <= 1'b1;
                    end else if (op == OP_STORE_WORKING) begin
                        mem_addr <= file_addr;
                        mem_wdata <= working;
                        mem_wr_en <= 1'b1;
                    end
                end
                default: begin
                    mem_rd_en <= 1'b0;
                end
            endcase
        end
    end

    // core registers written at the close of phase four; no flag is touched here
    // a load lands before the next decode, so the following store already sees it
    always @(posedge core_clk) begin
        if (srst) begin
            working <= `RST_WORKING;
            bank_select_register <= `RST_BANK;
        end else if (phase == `PH_Q4) begin
            if (op == OP_LOAD_WORKING) begin
                working <= literal;
            end
            if (op == OP_LOAD_BANK) begin
                bank_select_register <= literal[3:0];
            end
        end
    end

endmodule

// ===== data_move_defines.vh
// opcode fields, address layout and phase numbering for the data-move executer
// assumes a 16-bit program word and a 12-bit byte-addressed data space
//
// What this block does
// - file copy takes 12-bit source and destination, whole space, no banking
// - file copy is two words: nibble 1100 plus source, nibble 1111 plus destination
// - file copy writes source byte unchanged to destination, no flag changes
// - file copy: two cycles; source read in phase two, destination written phase four
// - opcode 0000 0001 loads literal into bank select, low nibble used, one cycle
// - store working to 8-bit file address; access bit 0 access bank, 1 banked
`ifndef DATA_MOVE_DEFINES_VH
`define DATA_MOVE_DEFINES_VH

// quarter phases of one instruction cycle
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

// opcode fields of the program word
`define NIB_COPY_SRC 4'hc
`define NIB_COPY_DST 4'hf
`define BYTE_LOAD_BANK 8'h01
`define BYTE_LOAD_WORKING 8'h0e
`define SEVEN_STORE_WORKING 7'h37

// access bank split: low half maps to page 0, high half to the top page
`define ACCESS_SPLIT_BIT 7
`define PAGE_LOW 4'h0
`define PAGE_HIGH 4'hf

// reset values
`define RST_WORKING 8'h00
`define RST_BANK 4'h0

`endif

// ===== data_move_exec_asserts.sv
// checker for the data-move executer, watching its ports only
// assumes it is bound onto data_move_exec and memory reads settle within the read cycle
`timescale 1ns/1ps
`include "data_move_defines.vh"
module data_move_asserts #(
    parameter ADDR_W = 12,
    parameter DATA_W = 8
) (
    input wire core_clk,
    input wire srst,
    input wire [15:0] instr_word,
    input wire instr_valid,
    input wire skip_in,
    input wire [DATA_W-1:0] mem_rdata,
    input wire [ADDR_W-1:0] mem_addr,
    input wire mem_rd_en,
    input wire mem_wr_en,
    input wire [DATA_W-1:0] mem_wdata,
    input wire [DATA_W-1:0] working,
    input wire [3:0] bank_select_register,
    input wire [1:0] phase,
    input wire copy_pending,
    input wire illegal_word
);
    // a word is taken at the edge closing phase one, unless flushed
    wire take = phase == `PH_Q1 && instr_valid && !skip_in;
    wire first = take && !copy_pending;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // second copy cycle: no read at all, write strobe in the last quarter
    sequence dst_write;
        !mem_rd_en [*2] ##1 mem_wr_en;
    endsequence
    AST_RD_Q2: assert property (mem_rd_en |-> phase == `PH_Q2)
        else $error("read strobe outside phase two");
    AST_WR_Q4: assert property (mem_wr_en |-> phase == `PH_Q4)
        else $error("write strobe outside phase four");
    AST_COPY_SRC: assert property (first && instr_word[15:12] == `NIB_COPY_SRC |=>
        mem_rd_en && mem_addr == $past(instr_word[11:0]) ##1 copy_pending)
        else $error("copy source read wrong");
    // a skipped copy shows no source read three clocks back and writes nothing
    AST_COPY_DST: assert property (take && copy_pending &&
        instr_word[15:12] == `NIB_COPY_DST && $past(mem_rd_en, 3) |=> dst_write ##0
        mem_addr == $past(instr_word[11:0], 3) && mem_wdata == $past(mem_rdata, 6))
        else $error("copy destination write wrong");
    AST_BANK: assert property (first && instr_word[15:8] == `BYTE_LOAD_BANK |->
        ##4 bank_select_register == $past(instr_word[3:0], 4))
        else $error("bank select not loaded");
    AST_WORKING: assert property (first && instr_word[15:8] == `BYTE_LOAD_WORKING |->
        ##4 working == $past(instr_word[7:0], 4))
        else $error("working register not loaded");
    AST_STORE: assert property (first && instr_word[15:9] == `SEVEN_STORE_WORKING |->
        ##3 mem_wr_en && mem_wdata == $past(working, 3))
        else $error("working register not stored");
endmodule
bind data_move_exec data_move_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .core_clk(core_clk), .srst(srst), .instr_word(instr_word), .instr_valid(instr_valid),
    .skip_in(skip_in), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
    .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .working(working),
    .bank_select_register(bank_select_register), .phase(phase),
    .copy_pending(copy_pending), .illegal_word(illegal_word));

// ===== testbench.sv
// self-checking bench for the data-move executer with a behavioural data memory
// assumes the checker is bound from its own file; skip_in rises only in the skip scenario
`timescale 1ns/1ps
module testbench;
    reg core_clk, srst, instr_valid, skip_in;
    reg [15:0] instr_word;
    reg [7:0] mem [0:4095];
    integer err_count, checks_done;
    wire [11:0] mem_addr;
    wire mem_rd_en, mem_wr_en, copy_pending, illegal_word;
    wire [7:0] mem_wdata, working, mem_rdata;
    wire [3:0] bank_select_register;
    wire [1:0] phase;
    // read data is scrambled outside the strobe so a late sample cannot pass
    assign mem_rdata = mem_rd_en ? mem[mem_addr] : ~mem[mem_addr];
    // memory write lands at the edge closing the strobe cycle
    always @(posedge core_clk) begin
        if (mem_wr_en) mem[mem_addr] <= mem_wdata;
    end
    data_move_exec i_data_move_exec (.core_clk(core_clk), .srst(srst),
        .instr_word(instr_word), .instr_valid(instr_valid), .skip_in(skip_in),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
        .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .working(working),
        .bank_select_register(bank_select_register), .phase(phase),
        .copy_pending(copy_pending), .illegal_word(illegal_word));
    // free-running clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task chk(input [8*12-1:0] what, input [7:0] exp, input [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("FAIL %0s expected %h seen %h", what, exp, got);
        end
    endtask
    // present one word in phase one, held for that single quarter
    task issue(input [15:0] w);
        @(negedge core_clk);
        while (phase !== 2'h0) @(negedge core_clk);
        instr_word = w;
        instr_valid = 1'b1;
        @(negedge core_clk);
        instr_valid = 1'b0;
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // copy between the two ends of the data space, words back to back
    task t_copy;
        mem[12'hfff] = 8'h33;
        mem[12'h000] = 8'h11;
        issue(16'hcfff);
        issue(16'hf000);
        repeat (4) @(negedge core_clk);
        chk("copy dest", 8'h33, mem[12'h000]);
        chk("copy source", 8'h33, mem[12'hfff]);
    endtask
    task t_literals;
        issue(16'h01a5);
        issue(16'h0e5a);
        repeat (4) @(negedge core_clk);
        chk("bank", 8'h05, {4'h0, bank_select_register});
        chk("working", 8'h5a, working);
    endtask
    // banked store, then both halves of the access bank
    task t_store;
        issue(16'h6f42);
        issue(16'h6e90);
        issue(16'h6e10);
        repeat (4) @(negedge core_clk);
        chk("banked", 8'h5a, mem[12'h542]);
        chk("access hi", 8'h5a, mem[12'hf90]);
        chk("access lo", 8'h5a, mem[12'h010]);
    endtask
    // skipped copy eats its second word; a copy missing its second word writes nothing
    task t_skip_illegal;
        mem[12'h010] = 8'h66;
        mem[12'h011] = 8'h77;
        skip_in = 1'b1;
        issue(16'hc010);
        skip_in = 1'b0;
        chk("skip pending", 8'h01, {7'h00, copy_pending});
        issue(16'hf011);
        chk("skip illegal", 8'h00, {7'h00, illegal_word});
        issue(16'hc010);
        issue(16'h0e77);
        chk("illegal", 8'h01, {7'h00, illegal_word});
        repeat (4) @(negedge core_clk);
        chk("skip dest", 8'h77, mem[12'h011]);
        chk("no junk", 8'h33, mem[12'h000]);
        chk("no load", 8'h5a, working);
        chk("src kept", 8'h66, mem[12'h010]);
    endtask
    // main sequence
    initial begin
        err_count = 0;
        checks_done = 0;
        srst = 1'b1;
        instr_valid = 1'b0;
        skip_in = 1'b0;
        instr_word = 16'h0000;
        repeat (10) @(negedge core_clk);
        srst = 1'b0;
        t_copy;
        t_literals;
        t_store;
        t_skip_illegal;
        give_verdict;
    end
    // the whole run needs well under a microsecond
    initial begin
        #5000;
        err_count = err_count + 1;
        give_verdict;
    end
endmodule
